/* logic/gesture_pkg.sv */
// Overview of operation
// [RULE1] positive swipe moves away from origin, negative toward it
// [RULE2] swipe axis is the axis the motion runs roughly parallel to
// [RULE3] swipe needs initial distance per axis from the start coordinate
// [RULE4] initial distance must be covered within swipe time from touch start
// [RULE5] start-to-qualify line must be within angle threshold of some axis
// [RULE6] directional swipe output pulses for exactly one sensing cycle
// [RULE7] per-cycle relative X and Y movement is reported throughout
// [RULE8] angle threshold is 64 times tangent, compared as scaled slope
// [RULE9] swipe places its relative X/Y movement into gesture X/Y
// [RULE10] host may set 45 degrees and judge swipes from gesture X/Y
// [RULE11] swipe-hold needs movement under tap distance for full hold time
// [RULE12] swipe-hold output stays set until the finger lifts
// [RULE13] hold disabled: further swipes on consecutive distance and angle
// [RULE14] consecutive swipes ignore the swipe time limit
// [RULE15] same axis uses consecutive distance, other axis initial distance
// [RULE16] palm reported when touched channel count reaches palm threshold
// [RULE17] palm stays set until no channel is touched
// [RULE18] palm threshold should exceed the largest ordinary touch
// [RULE19] each gesture reported only when its enable bit is set (consecutive swipes skip the swipe enable check)
// [RULE20] second finger ignored, only first finger data evaluated
// [RULE21] hold time counted in ms, only while within tap distance
// [RULE22] finger release clears all per-touch swipe tracking state
// [RULE23] all conditions evaluated once per sensing cycle
// Purpose: constants and types for the swipe and palm gesture engine
// Assumes: coordinates are 16 bit pixels, times in ms ticks
// Notes:   register offsets are byte addresses on an axi4-lite slave
package gesture_pkg;

  localparam logic [7:0] REG_CTRL      = 8'h00;
  localparam logic [7:0] REG_INIT_DIST = 8'h04;
  localparam logic [7:0] REG_CONS_DIST = 8'h08;
  localparam logic [7:0] REG_TIMES     = 8'h0C;
  localparam logic [7:0] REG_ANGLE_TAP = 8'h10;
  localparam logic [7:0] REG_STATUS    = 8'h14;
  localparam logic [7:0] REG_GEST_XY   = 8'h18;
  localparam logic [7:0] REG_REL_XY    = 8'h1C;

  // ctrl field positions
  localparam int CTRL_EN_SWIPE = 0;
  localparam int CTRL_EN_HOLD  = 1;
  localparam int CTRL_EN_PALM  = 2;
  localparam int CTRL_PALM_LSB = 8;

  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam logic [31:0] INIT_DIST_RESET = 32'h0064_0064;
  localparam logic [31:0] CONS_DIST_RESET = 32'h0032_0032;
  localparam logic [31:0] TIMES_RESET     = 32'h012C_0096;
  localparam logic [31:0] ANGLE_TAP_RESET = 32'h0032_0017;

  localparam int ANGLE_SCALE_SHIFT = 6;
  localparam logic [1:0] AXI_OKAY   = 2'b00;
  localparam logic [1:0] AXI_SLVERR = 2'b10;

  typedef struct packed {
    logic        valid;
    logic        touched;
    logic [15:0] x;
    logic [15:0] y;
    logic [7:0]  chan_count;
  } frame_s;

  typedef struct packed {
    logic xpos;
    logic xneg;
    logic ypos;
    logic yneg;
  } dir_s;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b00,
    ST_TRACK = 2'b01,
    ST_SWIPED = 2'b11,
    ST_HELD  = 2'b10
  } swipe_state_e;

endpackage : gesture_pkg

/* logic/swipe_eval.sv */
// Purpose: combinational swipe qualification for one displacement
// Assumes: displacement is signed, thresholds are pixels
// Notes:   slope compared by cross multiply, no divider needed
`timescale 1ns/1ps
`default_nettype none
module swipe_eval
  import gesture_pkg::*;
(
  input  wire logic signed [16:0] dx_i,
  input  wire logic signed [16:0] dy_i,
  input  wire logic        [15:0] x_dist_i,
  input  wire logic        [15:0] y_dist_i,
  input  wire logic        [15:0] angle_i,
  output logic                    hit_o,
  output dir_s                    dir_o
);
  logic [16:0] ax;
  logic [16:0] ay;
  logic [33:0] ax_s;
  logic [33:0] ay_s;
  logic [33:0] ax_t;
  logic [33:0] ay_t;
  logic        x_ok;
  logic        y_ok;

  always_comb
  begin
    ax   = dx_i[16] ? 17'(-dx_i) : 17'(dx_i);
    ay   = dy_i[16] ? 17'(-dy_i) : 17'(dy_i);
    ax_s = {17'h0_0000, ax} << ANGLE_SCALE_SHIFT;
    ay_s = {17'h0_0000, ay} << ANGLE_SCALE_SHIFT;
    ax_t = 34'(ax) * 34'(angle_i);
    ay_t = 34'(ay) * 34'(angle_i);
    // 64*dy <= angle*dx means within angle of x axis
    x_ok = (ax >= {1'b0, x_dist_i}) && (ay_s <= ax_t); // [RULE3] [RULE5] [RULE8] [RULE2]
    y_ok = (ay >= {1'b0, y_dist_i}) && (ax_s <= ay_t); // [RULE3] [RULE5] [RULE8] [RULE2]
    hit_o = x_ok || y_ok;
    dir_o.xpos = x_ok && !dx_i[16]; // [RULE1]
    dir_o.xneg = x_ok && dx_i[16];
    dir_o.ypos = !x_ok && y_ok && !dy_i[16];
    dir_o.yneg = !x_ok && y_ok && dy_i[16];
  end
endmodule : swipe_eval
`default_nettype wire

/* logic/swipe_palm_gesture_engine.sv */
// Purpose: swipe, swipe-hold, consecutive swipe and palm detection
// Assumes: one frame_i.valid pulse per sensing cycle, ms_tick_i each ms
// Notes:   axi4-lite slave holds settings and results
//
// Design decisions made here: the placing of the registers and the AXI4-Lite interface to the registers.
`timescale 1ns/1ps
`default_nettype none
module swipe_palm_gesture_engine
  import gesture_pkg::*;
(
  input  wire logic        mclk_i,
  input  wire logic        reset_i,
  input  wire logic        ce_i,
  input  wire logic        ms_tick_i,
  input  wire frame_s      frame_i,
  output dir_s             swipe_o,
  output dir_s             swipe_hold_o,
  output logic             palm_o,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [7:0]  awaddr,
  input  wire logic        wvalid,
  output logic             wready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  output logic             bvalid,
  input  wire logic        bready,
  output logic [1:0]       bresp,
  input  wire logic        arvalid,
  output logic             arready,
  input  wire logic [7:0]  araddr,
  output logic             rvalid,
  input  wire logic        rready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp
);
  function automatic logic [31:0] merge(input logic [31:0] o, input logic [31:0] n,
                                        input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++)
      if (s[i]) r[i*8 +: 8] = n[i*8 +: 8];
    return r;
  endfunction : merge

  function automatic logic signed [16:0] diff(input logic [15:0] a, input logic [15:0] b);
    return 17'($signed({1'b0, a}) - $signed({1'b0, b}));
  endfunction : diff

  logic [31:0] ctrl, init_dist, cons_dist, times, angle_tap;
  logic [31:0] next_ctrl, next_init_dist, next_cons_dist, next_times, next_angle_tap;
  logic        aw_got, w_got, next_aw_got, next_w_got;
  logic [7:0]  aw_q, next_aw_q;
  logic [31:0] w_q, next_w_q;
  logic [3:0]  s_q, next_s_q;
  logic        next_bvalid, next_rvalid;
  logic [1:0]  next_bresp, next_rresp;
  logic [31:0] next_rdata;

  swipe_state_e state, next_state;
  logic [15:0] sx, sy, lx, ly, px, py, hx, hy;
  logic [15:0] next_sx, next_sy, next_lx, next_ly, next_px, next_py, next_hx, next_hy;
  logic [15:0] t_ms, next_t_ms;
  logic        last_x, next_last_x;
  dir_s        next_swipe, hold_dir, next_hold_dir, next_swipe_hold;
  logic        next_palm;
  logic [15:0] rel_x, rel_y, gx, gy, next_rel_x, next_rel_y, next_gx, next_gy;

  logic        w_fire;
  logic        hit_a, hit_c;
  dir_s        dir_a, dir_c;
  logic [15:0] cx_dist, cy_dist;
  logic signed [16:0] hdx, hdy;
  logic [16:0] ahx, ahy;

  // initial from start point, consecutive from last swipe point
  swipe_eval u_eval_init (
    .dx_i     (diff(frame_i.x, sx)),
    .dy_i     (diff(frame_i.y, sy)),
    .x_dist_i (init_dist[15:0]),
    .y_dist_i (init_dist[31:16]),
    .angle_i  (angle_tap[15:0]),
    .hit_o    (hit_a),
    .dir_o    (dir_a)
  );
  swipe_eval u_eval_cons (
    .dx_i     (diff(frame_i.x, px)),
    .dy_i     (diff(frame_i.y, py)),
    .x_dist_i (cx_dist),
    .y_dist_i (cy_dist),
    .angle_i  (angle_tap[15:0]),
    .hit_o    (hit_c),
    .dir_o    (dir_c)
  );

  always_comb
  begin
    cx_dist = last_x ? cons_dist[15:0] : init_dist[15:0]; // [RULE15]
    cy_dist = last_x ? init_dist[31:16] : cons_dist[31:16]; // [RULE15]
    hdx = diff(frame_i.x, hx);
    hdy = diff(frame_i.y, hy);
    ahx = hdx[16] ? 17'(-hdx) : 17'(hdx);
    ahy = hdy[16] ? 17'(-hdy) : 17'(hdy);
  end

  // gesture engine next state
  always_comb
  begin
    next_state = state;
    next_sx = sx; next_sy = sy; next_lx = lx; next_ly = ly;
    next_px = px; next_py = py; next_hx = hx; next_hy = hy;
    next_t_ms = t_ms;
    next_last_x = last_x;
    next_hold_dir = hold_dir;
    next_swipe = swipe_o;
    next_swipe_hold = swipe_hold_o;
    next_palm = palm_o;
    next_rel_x = rel_x; next_rel_y = rel_y; next_gx = gx; next_gy = gy;
    if (ms_tick_i && t_ms != 16'hFFFF)
      next_t_ms = t_ms + 16'h0001; // [RULE4] [RULE21]
    if (frame_i.valid) // [RULE23]
    begin
      // pulse lasts one sensing cycle, cleared at next frame
      next_swipe = '0; // [RULE6]
      // palm uses channel count, independent of finger tracking
      if (ctrl[CTRL_EN_PALM] && frame_i.chan_count >= ctrl[CTRL_PALM_LSB +: 8]
          && frame_i.chan_count != 8'h00)
        next_palm = 1'b1; // [RULE16] [RULE19]
      else if (frame_i.chan_count == 8'h00)
        next_palm = 1'b0; // [RULE17]
      if (!frame_i.touched)
      begin
        // release wipes all per-touch tracking
        next_state = ST_IDLE; // [RULE22]
        next_t_ms = '0;
        next_swipe_hold = '0; // [RULE12]
        next_rel_x = '0;
        next_rel_y = '0;
      end
      else
      begin
        // frame x/y is always the first finger, later fingers ignored
        next_rel_x = 16'(diff(frame_i.x, lx)); // [RULE7] [RULE20]
        next_rel_y = 16'(diff(frame_i.y, ly)); // [RULE7]
        next_lx = frame_i.x;
        next_ly = frame_i.y;
        case (state)
          ST_IDLE:
          begin
            next_sx = frame_i.x; next_sy = frame_i.y;
            next_rel_x = '0; next_rel_y = '0;
            next_t_ms = '0;
            next_state = ST_TRACK;
          end
          ST_TRACK:
          begin
            if (hit_a && t_ms <= times[15:0] && ctrl[CTRL_EN_SWIPE]) // [RULE4] [RULE19]
            begin
              next_swipe = dir_a; // [RULE6]
              next_gx = 16'(diff(frame_i.x, sx)); // [RULE9]
              next_gy = 16'(diff(frame_i.y, sy)); // [RULE9]
              next_last_x = dir_a.xpos | dir_a.xneg;
              next_hold_dir = dir_a;
              next_px = frame_i.x; next_py = frame_i.y;
              next_hx = frame_i.x; next_hy = frame_i.y;
              next_t_ms = '0;
              next_state = ST_SWIPED;
            end
          end
          ST_SWIPED:
          begin
            if (ctrl[CTRL_EN_HOLD])
            begin
              if (ahx >= {1'b0, angle_tap[31:16]} || ahy >= {1'b0, angle_tap[31:16]})
              begin
                next_hx = frame_i.x; next_hy = frame_i.y; // [RULE21]
                next_t_ms = '0;
              end
              else if (t_ms >= times[31:16])
              begin
                next_swipe_hold = hold_dir; // [RULE11]
                next_state = ST_HELD;
              end
            end
            else if (hit_c) // [RULE13] [RULE14]
            begin
              next_swipe = dir_c;
              next_gx = 16'(diff(frame_i.x, px));
              next_gy = 16'(diff(frame_i.y, py));
              next_last_x = dir_c.xpos | dir_c.xneg;
              next_px = frame_i.x; next_py = frame_i.y;
            end
          end
          ST_HELD: next_state = ST_HELD; // [RULE12]
          default: next_state = ST_IDLE;
        endcase
      end
    end
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      state <= ST_IDLE;
      sx <= '0; sy <= '0; lx <= '0; ly <= '0;
      px <= '0; py <= '0; hx <= '0; hy <= '0;
      t_ms <= '0; last_x <= 1'b0;
      hold_dir <= '0; swipe_o <= '0; swipe_hold_o <= '0; palm_o <= 1'b0;
      rel_x <= '0; rel_y <= '0; gx <= '0; gy <= '0;
    end
    else if (ce_i)
    begin
      state <= next_state;
      sx <= next_sx; sy <= next_sy; lx <= next_lx; ly <= next_ly;
      px <= next_px; py <= next_py; hx <= next_hx; hy <= next_hy;
      t_ms <= next_t_ms; last_x <= next_last_x;
      hold_dir <= next_hold_dir;
      swipe_o <= next_swipe;
      swipe_hold_o <= next_swipe_hold; palm_o <= next_palm;
      rel_x <= next_rel_x; rel_y <= next_rel_y; gx <= next_gx; gy <= next_gy;
    end
  end

  // axi4-lite slave, address and data accepted in either order
  always_comb
  begin
    awready = !aw_got && !bvalid;
    wready  = !w_got && !bvalid;
    arready = !rvalid;
    next_aw_got = aw_got; next_w_got = w_got;
    next_aw_q = aw_q; next_w_q = w_q; next_s_q = s_q;
    next_bvalid = bvalid; next_bresp = bresp;
    next_rvalid = rvalid; next_rresp = rresp; next_rdata = rdata;
    next_ctrl = ctrl; next_init_dist = init_dist; next_cons_dist = cons_dist;
    next_times = times; next_angle_tap = angle_tap;
    if (awvalid && awready)
    begin
      next_aw_got = 1'b1;
      next_aw_q = awaddr;
    end
    if (wvalid && wready)
    begin
      next_w_got = 1'b1;
      next_w_q = wdata;
      next_s_q = wstrb;
    end
    w_fire = next_aw_got && next_w_got && !bvalid;
    if (w_fire)
    begin
      next_aw_got = 1'b0; next_w_got = 1'b0;
      next_bvalid = 1'b1;
      next_bresp = AXI_OKAY;
      if (next_aw_q == REG_CTRL)
        next_ctrl = merge(ctrl, next_w_q, next_s_q);
      else if (next_aw_q == REG_INIT_DIST)
        next_init_dist = merge(init_dist, next_w_q, next_s_q);
      else if (next_aw_q == REG_CONS_DIST)
        next_cons_dist = merge(cons_dist, next_w_q, next_s_q);
      else if (next_aw_q == REG_TIMES)
        next_times = merge(times, next_w_q, next_s_q);
      else if (next_aw_q == REG_ANGLE_TAP)
        next_angle_tap = merge(angle_tap, next_w_q, next_s_q);
      else if (next_aw_q == REG_STATUS || next_aw_q == REG_GEST_XY || next_aw_q == REG_REL_XY)
        next_bresp = AXI_OKAY;
      else
        next_bresp = AXI_SLVERR;
    end
    else if (bvalid && bready)
      next_bvalid = 1'b0;
    if (arvalid && arready)
    begin
      next_rvalid = 1'b1;
      next_rresp = AXI_OKAY;
      if (araddr == REG_CTRL) next_rdata = ctrl;
      else if (araddr == REG_INIT_DIST) next_rdata = init_dist;
      else if (araddr == REG_CONS_DIST) next_rdata = cons_dist;
      else if (araddr == REG_TIMES) next_rdata = times;
      else if (araddr == REG_ANGLE_TAP) next_rdata = angle_tap;
      else if (araddr == REG_STATUS)
        next_rdata = {21'h0, palm_o, 2'(state), swipe_hold_o, swipe_o};
      else if (araddr == REG_GEST_XY) next_rdata = {gy, gx};
      else if (araddr == REG_REL_XY) next_rdata = {rel_y, rel_x};
      else
      begin
        next_rdata = 32'h0000_0000;
        next_rresp = AXI_SLVERR;
      end
    end
    else if (rvalid && rready)
      next_rvalid = 1'b0;
  end

  always_ff @(posedge mclk_i)
  begin
    if (reset_i)
    begin
      aw_got <= 1'b0; w_got <= 1'b0; aw_q <= '0; w_q <= '0; s_q <= '0;
      bvalid <= 1'b0; bresp <= AXI_OKAY; rvalid <= 1'b0; rresp <= AXI_OKAY;
      rdata <= '0;
      ctrl <= CTRL_RESET; init_dist <= INIT_DIST_RESET; cons_dist <= CONS_DIST_RESET;
      times <= TIMES_RESET; angle_tap <= ANGLE_TAP_RESET;
    end
    else if (ce_i)
    begin
      aw_got <= next_aw_got; w_got <= next_w_got; aw_q <= next_aw_q;
      w_q <= next_w_q; s_q <= next_s_q;
      bvalid <= next_bvalid; bresp <= next_bresp;
      rvalid <= next_rvalid; rresp <= next_rresp; rdata <= next_rdata;
      ctrl <= next_ctrl; init_dist <= next_init_dist; cons_dist <= next_cons_dist;
      times <= next_times; angle_tap <= next_angle_tap;
    end
  end
endmodule : swipe_palm_gesture_engine
`default_nettype wire

/* verif/axi_host_model.sv */
// Purpose: host side bus master reading and writing engine settings
// Assumes: write address and data offered together
// Notes:   released address lines show inverted values, not stale ones
`timescale 1ns/1ps
`default_nettype none
module axi_host_model
(
  input  wire logic        mclk_i,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [7:0]       awaddr,
  output logic             wvalid,
  input  wire logic        wready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  input  wire logic        bvalid,
  output logic             bready,
  input  wire logic [1:0]  bresp,
  output logic             arvalid,
  input  wire logic        arready,
  output logic [7:0]       araddr,
  input  wire logic        rvalid,
  output logic             rready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp
);
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready} = 5'h0;
    {awaddr, araddr, wdata} = 48'h0;
    wstrb = 4'hf;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_done;
    logic w_done;
    {aw_done, w_done} = 2'b00;
    @(posedge mclk_i);
    awvalid <= 1'b1;
    awaddr  <= a;
    wvalid  <= 1'b1;
    wdata   <= d;
    bready  <= 1'b1;
    while (!(aw_done && w_done))
    begin
      @(posedge mclk_i);
      if (awvalid && awready)
      begin
        aw_done = 1'b1;
        awvalid <= 1'b0;
        awaddr  <= ~a;
      end
      if (wvalid && wready)
      begin
        w_done = 1'b1;
        wvalid <= 1'b0;
        wdata  <= ~d;
      end
    end
    do @(posedge mclk_i); while (!bvalid);
    r = bresp;
    bready <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    @(posedge mclk_i);
    arvalid <= 1'b1;
    araddr  <= a;
    rready  <= 1'b1;
    do @(posedge mclk_i); while (!arready);
    arvalid <= 1'b0;
    araddr  <= ~a;
    do @(posedge mclk_i); while (!rvalid);
    d = rdata;
    r = rresp;
    rready <= 1'b0;
  endtask : rd
endmodule : axi_host_model
`default_nettype wire

/* verif/swipe_palm_gesture_engine_tb_top.sv */
// Purpose: self-checking bench for the swipe and palm engine
// Assumes: two clocks per ms tick, frames spaced by the bench
// Notes:   time limits probed with margin, the tick phase is loose
`timescale 1ns/1ps
`default_nettype none
module swipe_palm_gesture_engine_tb_top;
  import gesture_pkg::*;
  logic        mclk_i, reset_i, ce_i, ms_tick_i, palm_o;
  frame_s      frame_i;
  dir_s        swipe_o, swipe_hold_o;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp;
  int          mismatches, tests_run;
  localparam dir_s XP = 4'b1000, XN = 4'b0100, YP = 4'b0010, YN = 4'b0001, NO = 4'b0000;
  swipe_palm_gesture_engine swipe_palm_gesture_engine_i (
    .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .ms_tick_i(ms_tick_i), .frame_i(frame_i),
    .swipe_o(swipe_o), .swipe_hold_o(swipe_hold_o), .palm_o(palm_o), .awvalid(awvalid),
    .awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata),
    .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
    .arready(arready), .araddr(araddr), .rvalid(rvalid), .rready(rready), .rdata(rdata),
    .rresp(rresp));
  axi_host_model axi_host_model_i (
    .mclk_i(mclk_i), .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .wvalid(wvalid),
    .wready(wready), .wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
    .bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr), .rvalid(rvalid),
    .rready(rready), .rdata(rdata), .rresp(rresp));
  initial
  begin
    mclk_i = 1'b0;
    forever #12.5 mclk_i = ~mclk_i;
  end
  task automatic summarize;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask : summarize
  task automatic chk_dir(input string n, input dir_s e, input dir_s g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %b seen %b", n, e, g);
    end
  endtask : chk_dir
  task automatic chk_w(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e)
    begin
      mismatches++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask : chk_w
  task automatic wreg(input logic [7:0] a, input logic [31:0] d);
    logic [1:0] r;
    axi_host_model_i.wr(a, d, r);
    chk_w("bresp", 32'h0, {30'h0, r});
  endtask : wreg
  task automatic rdc(input logic [7:0] a, input logic [31:0] e, input logic [1:0] er);
    logic [31:0] d;
    logic [1:0]  r;
    axi_host_model_i.rd(a, d, r);
    chk_w("rdata", e, d);
    chk_w("rresp", {30'h0, er}, {30'h0, r});
  endtask : rdc
  task automatic ms(input int n);
    repeat (n)
    begin
      @(posedge mclk_i);
      ms_tick_i <= 1'b1;
      @(posedge mclk_i);
      ms_tick_i <= 1'b0;
    end
  endtask : ms
  // fields stay put between frames, only valid pulses
  task automatic frm(input int x, input int y, input logic t, input int c);
    @(posedge mclk_i);
    frame_i <= '{1'b1, t, x[15:0], y[15:0], c[7:0]};
    @(posedge mclk_i);
    frame_i.valid <= 1'b0;
    @(negedge mclk_i);
  endtask : frm
  task automatic swipe(input int x, input int y, input int t, input dir_s e);
    frm(0, 0, 1'b0, 0);
    frm(500, 500, 1'b1, 1);
    ms(t);
    frm(x, y, 1'b1, 1);
    chk_dir("swipe", e, swipe_o);
    frm(x, y, 1'b1, 1);
    chk_dir("swipe_end", NO, swipe_o);
  endtask : swipe
  task automatic t_regs;
    logic [7:0]  a [6] = '{REG_CTRL, REG_INIT_DIST, REG_CONS_DIST, REG_TIMES, REG_ANGLE_TAP,
                           8'h20};
    logic [31:0] e [6] = '{CTRL_RESET, INIT_DIST_RESET, CONS_DIST_RESET, TIMES_RESET,
                           ANGLE_TAP_RESET, 32'h0};
    foreach (a[i])
      rdc(a[i], e[i], (i == 5) ? AXI_SLVERR : AXI_OKAY);
  endtask : t_regs
  task automatic t_dirs;
    int   xs [4] = '{600, 400, 535, 465};
    int   ys [4] = '{535, 465, 600, 400};
    dir_s es [4] = '{XP, XN, YP, YN};
    foreach (xs[i])
      swipe(xs[i], ys[i], 10, es[i]);
    rdc(REG_GEST_XY, 32'hff9c_ffdd, AXI_OKAY);
  endtask : t_dirs
  task automatic t_limits;
    swipe(599, 500, 10, NO);
    swipe(600, 536, 10, NO);
    swipe(600, 500, 160, NO);
    swipe(600, 500, 140, XP);
  endtask : t_limits
  task automatic t_consec;
    swipe(600, 500, 10, XP);
    ms(200);
    frm(640, 500, 1'b1, 1);
    chk_dir("consec_short", NO, swipe_o);
    rdc(REG_REL_XY, 32'h0000_0028, AXI_OKAY);
    frm(700, 500, 1'b1, 1);
    chk_dir("consec_x", XP, swipe_o);
    frm(700, 560, 1'b1, 1);
    chk_dir("cross_short", NO, swipe_o);
    frm(700, 700, 1'b1, 1);
    chk_dir("cross_y", YP, swipe_o);
  endtask : t_consec
  task automatic t_hold;
    wreg(REG_CTRL, 32'h0000_0507);
    swipe(600, 500, 10, XP);
    ms(250);
    frm(660, 500, 1'b1, 1);
    ms(100);
    frm(660, 500, 1'b1, 1);
    chk_dir("hold_early", NO, swipe_hold_o);
    ms(250);
    frm(660, 500, 1'b1, 1);
    chk_dir("hold_set", XP, swipe_hold_o);
    rdc(REG_STATUS, 32'h0000_0280, AXI_OKAY);
    frm(660, 500, 1'b1, 1);
    chk_dir("hold_kept", XP, swipe_hold_o);
    frm(0, 0, 1'b0, 0);
    chk_dir("hold_lift", NO, swipe_hold_o);
  endtask : t_hold
  task automatic t_palm;
    int   cs [4] = '{4, 5, 1, 0};
    logic ps [4] = '{1'b0, 1'b1, 1'b1, 1'b0};
    // clock enable low must swallow a whole frame
    @(posedge mclk_i);
    ce_i <= 1'b0;
    frm(10, 10, 1'b1, 5);
    chk_w("palm_frozen", 32'h0, {31'h0, palm_o});
    @(posedge mclk_i);
    ce_i <= 1'b1;
    foreach (cs[i])
    begin
      frm(10, 10, cs[i] != 0, cs[i]);
      chk_w("palm", {31'h0, ps[i]}, {31'h0, palm_o});
    end
  endtask : t_palm
  task automatic t_wide;
    wreg(REG_ANGLE_TAP, 32'h0032_0040);
    swipe(600, 560, 10, XP);
    rdc(REG_GEST_XY, 32'h003c_0064, AXI_OKAY);
  endtask : t_wide
  initial
  begin
    {reset_i, ce_i, ms_tick_i} = 3'b110;
    frame_i = '0;
    {mismatches, tests_run} = '0;
    repeat (2) @(posedge mclk_i);
    reset_i <= 1'b0;
    t_regs();
    swipe(600, 500, 10, NO);
    wreg(REG_CTRL, 32'h0000_0505);
    t_dirs();
    t_limits();
    t_consec();
    t_hold();
    t_palm();
    t_wide();
    summarize();
  end
  // hang guard, well past the expected few thousand cycles
  initial
  begin
    #(25 * 40000);
    mismatches++;
    summarize();
  end
endmodule : swipe_palm_gesture_engine_tb_top
`default_nettype wire

/* verif/swipe_palm_monitor.sv */
// Purpose: port checker for the gesture engine
// Assumes: frame fields held between valid pulses
// Notes:   bound into the engine at the foot of this file
`timescale 1ns/1ps
`default_nettype none
module swipe_palm_monitor
  import gesture_pkg::*;
(
  input wire logic   mclk_i,
  input wire logic   reset_i,
  input wire logic   ce_i,
  input wire frame_s frame_i,
  input wire dir_s   swipe_o,
  input wire dir_s   swipe_hold_o,
  input wire logic   palm_o
);
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (reset_i);
  sequence s_frame;
    frame_i.valid && ce_i;
  endsequence
  sequence s_lift;
    s_frame ##0 !frame_i.touched;
  endsequence
  a_swipe_one_hot:
    assert property ($onehot0(swipe_o)) else $error("two swipe directions at once");
  a_swipe_on_frame:
    assert property ($changed(swipe_o) |-> $past(frame_i.valid && ce_i))
    else $error("swipe output moved off a frame");
  a_swipe_touched:
    assert property ($rose(|swipe_o) |-> frame_i.touched) else $error("swipe without touch");
  a_hold_stays:
    assert property ((|swipe_hold_o) ##0 s_frame ##0 frame_i.touched |=>
      swipe_hold_o == $past(swipe_hold_o)) else $error("swipe hold dropped early");
  a_lift_clears:
    assert property (s_lift |=> swipe_o == '0 && swipe_hold_o == '0)
    else $error("lift left a swipe flag");
  a_hold_on_frame:
    assert property ($rose(|swipe_hold_o) |-> $past(frame_i.valid))
    else $error("swipe hold rose off a frame");
  a_palm_rise:
    assert property ($rose(palm_o) |-> $past(frame_i.valid && frame_i.chan_count != 8'h00))
    else $error("palm without touched channels");
  a_palm_stays:
    assert property (palm_o ##0 s_frame ##0 frame_i.chan_count != 8'h00 |=> palm_o)
    else $error("palm cleared while touched");
  a_palm_clears:
    assert property (palm_o ##0 s_frame ##0 frame_i.chan_count == 8'h00 |=> !palm_o)
    else $error("palm kept after full release");
endmodule : swipe_palm_monitor
bind swipe_palm_gesture_engine swipe_palm_monitor swipe_palm_monitor_i (
  .mclk_i(mclk_i), .reset_i(reset_i), .ce_i(ce_i), .frame_i(frame_i),
  .swipe_o(swipe_o), .swipe_hold_o(swipe_hold_o), .palm_o(palm_o));
`default_nettype wire
